// ### src/cpuam_regs.vh
// Operation
// - normal mode reaches at most a 64-kbyte space, 16-bit addresses out
// - advanced mode reaches a 16-Mbyte space through 24-bit addresses
// - operating mode comes only from the external mode pin
// - upper halves keep any written value in normal mode
// - pre-decrement and post-increment carries ripple into the upper half
// - normal mode uses only the low 16 bits of each effective address
// - normal vector table starts at zero, one 16-bit entry per vector
// - memory-indirect branches use an 8-bit absolute operand address
// - normal indirect operand is a 16-bit word below 0x0100
// - calls push the pointer; exceptions also push flags and valid extended control
// - advanced upper halves serve as 16-bit or top-of-32-bit registers
// - advanced vectors are 32-bit slots, low 24 bits give the target
// - advanced indirect operand is a longword with top byte forced zero
// - advanced indirect operands lie between zero and 0x000000ff
// - advanced mode offers linear access up to 16 Mbytes
// - eight 32-bit general registers plus control registers
// - 24-bit instruction pointer, bit zero reads as zero on fetch
// - extended control: bit 7 trace, bits 2..0 mask, bits 6..3 read one
// - eighth general register is the stack pointer for calls and exceptions
// - reset loads pointer from vector zero, clears trace, sets mask bits
`ifndef CPUAM_REGS_VH
`define CPUAM_REGS_VH
`define CPUAM_OFS_GPR0 8'h00
`define CPUAM_OFS_PC 8'h20
`define CPUAM_OFS_XCTL 8'h24
`define CPUAM_OFS_COND 8'h28
`define CPUAM_OFS_STAT 8'h2c
`define CPUAM_OFS_CMD 8'h30
`define CPUAM_OFS_EFF_ADDR 8'h34
`define CPUAM_OFS_CFG 8'h38
`define CPUAM_CMD_OP_HI 2
`define CPUAM_CMD_OP_LO 0
`define CPUAM_CMD_REG_HI 10
`define CPUAM_CMD_REG_LO 8
`define CPUAM_CMD_LONG_BIT 12
`define CPUAM_CMD_ARG_HI 23
`define CPUAM_CMD_ARG_LO 16
`define CPUAM_OP_EXC 3'h2
`define CPUAM_OP_JUMP 3'h3
`define CPUAM_OP_CALL 3'h4
`define CPUAM_OP_PREDEC 3'h5
`define CPUAM_OP_POSTINC 3'h6
`define CPUAM_XCTL_TRACE_BIT 7
`define CPUAM_XCTL_RSVD 8'h78
`define CPUAM_XCTL_RST 8'h07
`define CPUAM_COND_I_BIT 7
`define CPUAM_COND_RST 8'h80
`define CPUAM_ADDR_NORM_MASK 24'h00ffff
`define CPUAM_ADDR_ADV_MASK 24'hffffff
`define CPUAM_BOOT_CYCLES 2'h3
`endif

// ### src/cpuam_core.v
`timescale 1ns/1ns
`include "cpuam_regs.vh"
module cpuam_core (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // mode pin, high selects advanced mode
  input wire mode_pin,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // memory port for vectors, branch tables and stack
  output reg mem_req,
  output reg mem_we,
  output reg mem_long,
  output reg [23:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack
);
  // sequencer states
  localparam S_BOOT = 3'h0;
  localparam S_IDLE = 3'h1;
  localparam S_PUSH_PC = 3'h2;
  localparam S_PUSH_COND = 3'h3;
  localparam S_PUSH_XCTL = 3'h4;
  localparam S_FETCH = 3'h5;

  // architectural registers
  reg [31:0] gpr_r [0:7];
  reg [23:0] pc_r;
  reg [7:0] xctl_r;
  reg [7:0] cond_r;
  reg [23:0] eff_addr_r;
  reg xctl_valid_r;

  // mode and sequencer state
  reg adv_r;
  reg [2:0] mode_sync_r;
  reg [2:0] state_r;
  reg [1:0] boot_cnt_r;
  reg exc_r;
  reg fetch_ind_r;
  reg [7:0] arg_r;

  // write buffers
  reg [7:0] awaddr_r;
  reg aw_full_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_full_r;

  // combinational selections
  reg [31:0] rdata_nxt;
  reg [1:0] rresp_nxt;
  reg [31:0] push_data_nxt;
  reg [2:0] push_state_nxt;

  // sequencer status
  wire seq_busy = state_r != S_IDLE;
  wire boot_done = boot_cnt_r == `CPUAM_BOOT_CYCLES;

  // address and stack arithmetic
  wire [23:0] amask = adv_r ? `CPUAM_ADDR_ADV_MASK : `CPUAM_ADDR_NORM_MASK;
  wire push_long = adv_r && (state_r == S_PUSH_PC);
  wire [31:0] sp_dec = gpr_r[7] - (push_long ? 32'h4 : 32'h2);
  wire [23:0] push_addr = sp_dec[23:0] & amask;
  wire [7:0] xctl_view = xctl_r | `CPUAM_XCTL_RSVD;

  // write decode
  wire wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
  wire [7:0] waddr = awaddr_r & 8'hfc;
  wire [7:0] raddr = s_axi_araddr & 8'hfc;
  wire hit_gpr = waddr < `CPUAM_OFS_PC;
  wire hit_xctl = waddr == `CPUAM_OFS_XCTL;
  wire hit_cond = waddr == `CPUAM_OFS_COND;
  wire hit_cmd = waddr == `CPUAM_OFS_CMD;
  wire hit_cfg = waddr == `CPUAM_OFS_CFG;
  wire wr_map = hit_gpr || hit_xctl || hit_cond || hit_cmd || hit_cfg;
  wire [1:0] wr_resp = wr_map ? 2'h0 : 2'h2;
  wire [31:0] wcur = gpr_r[waddr[4:2]];
  wire [31:0] wmerged;

  // command fields
  wire cmd_go = wr_fire && hit_cmd && wstrb_r[0] && (state_r == S_IDLE);
  wire [2:0] cmd_op = wdata_r[`CPUAM_CMD_OP_HI:`CPUAM_CMD_OP_LO];
  wire [2:0] cmd_reg = wdata_r[`CPUAM_CMD_REG_HI:`CPUAM_CMD_REG_LO];
  wire [31:0] step = wdata_r[`CPUAM_CMD_LONG_BIT] ? 32'h4 : 32'h2;
  wire [31:0] reg_sel = gpr_r[cmd_reg];
  wire [31:0] reg_dec = reg_sel - step;
  wire [31:0] reg_inc = reg_sel + step;
  wire [7:0] vec_arg = wdata_r[`CPUAM_CMD_ARG_HI:`CPUAM_CMD_ARG_LO];
  wire [23:0] eff_dec = reg_dec[23:0] & amask;
  wire [23:0] eff_inc = reg_sel[23:0] & amask;
  wire [23:0] fetch_addr = fetch_ind_r ? {16'h0000, arg_r[7:1], 1'b0} :
                           (adv_r ? {14'h0000, arg_r, 2'b00} : {15'h0000, arg_r, 1'b0});
  wire [23:0] pc_fetched = adv_r ? {mem_rdata[23:1], 1'b0} :
                           {8'h00, mem_rdata[15:1], 1'b0};

  // ready outputs
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  assign s_axi_arready = !s_axi_rvalid;

  // byte lanes of a register write follow the strobes
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign wmerged[lane*8 +: 8] = wstrb_r[lane] ? wdata_r[lane*8 +: 8] : wcur[lane*8 +: 8];
    end
  endgenerate

  // mode pin synchroniser, change taken when stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_sync_r <= 3'h0;
      adv_r <= 1'b0;
    end else begin
      mode_sync_r <= {mode_sync_r[1:0], mode_pin};
      if (mode_sync_r[1] == mode_sync_r[2]) begin
        adv_r <= mode_sync_r[2];
      end
    end
  end

  // axi write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data selection
  always @* begin
    rdata_nxt = 32'h00000000;
    rresp_nxt = 2'h0;
    if (raddr < `CPUAM_OFS_PC) begin
      rdata_nxt = gpr_r[raddr[4:2]];
    end else begin
      case (raddr)
        `CPUAM_OFS_PC: rdata_nxt = {8'h00, pc_r[23:1], 1'b0};
        `CPUAM_OFS_XCTL: rdata_nxt = {24'h000000, xctl_view};
        `CPUAM_OFS_COND: rdata_nxt = {24'h000000, cond_r};
        `CPUAM_OFS_STAT: rdata_nxt = {30'h00000000, seq_busy, adv_r};
        `CPUAM_OFS_CMD: rdata_nxt = 32'h00000000;
        `CPUAM_OFS_EFF_ADDR: rdata_nxt = {8'h00, eff_addr_r};
        `CPUAM_OFS_CFG: rdata_nxt = {31'h00000000, xctl_valid_r};
        default: begin
          rresp_nxt = 2'h2;
        end
      endcase
    end
  end

  // axi read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_nxt;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // stack push data
  always @* begin
    push_data_nxt = {16'h0000, xctl_view, xctl_view};
    if (state_r == S_PUSH_PC) begin
      if (adv_r) begin
        push_data_nxt = {(exc_r ? cond_r : 8'h00), pc_r};
      end else begin
        push_data_nxt = {16'h0000, pc_r[15:0]};
      end
    end else if (state_r == S_PUSH_COND) begin
      push_data_nxt = {16'h0000, cond_r, cond_r};
    end
  end

  // order of pushes after each acknowledge
  always @* begin
    push_state_nxt = S_FETCH;
    if (state_r == S_PUSH_PC && exc_r && !adv_r) begin
      push_state_nxt = S_PUSH_COND;
    end else if (exc_r && xctl_valid_r && state_r != S_PUSH_XCTL) begin
      push_state_nxt = S_PUSH_XCTL;
    end
  end

  // register file and branch/stack sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= 24'h000000;
      xctl_r <= `CPUAM_XCTL_RST;
      cond_r <= `CPUAM_COND_RST;
      eff_addr_r <= 24'h000000;
      xctl_valid_r <= 1'b1;
      state_r <= S_BOOT;
      boot_cnt_r <= 2'h0;
      exc_r <= 1'b0;
      fetch_ind_r <= 1'b0;
      arg_r <= 8'h00;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_long <= 1'b0;
      mem_addr <= 24'h000000;
      mem_wdata <= 32'h00000000;
    end else begin
      if (wr_fire) begin
        if (hit_gpr) begin
          gpr_r[waddr[4:2]] <= wmerged;
        end else if (hit_xctl && wstrb_r[0]) begin
          xctl_r <= wdata_r[7:0] & ~`CPUAM_XCTL_RSVD;
        end else if (hit_cond && wstrb_r[0]) begin
          cond_r <= wdata_r[7:0];
        end else if (hit_cfg && wstrb_r[0]) begin
          xctl_valid_r <= wdata_r[0];
        end
      end
      case (state_r)
        S_BOOT: begin
          if (boot_done) begin
            state_r <= S_FETCH;
          end else begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
          end
        end
        S_IDLE: begin
          if (cmd_go) begin
            arg_r <= vec_arg;
            case (cmd_op)
              `CPUAM_OP_EXC: begin
                exc_r <= 1'b1;
                fetch_ind_r <= 1'b0;
                state_r <= S_PUSH_PC;
              end
              `CPUAM_OP_JUMP: begin
                exc_r <= 1'b0;
                fetch_ind_r <= 1'b1;
                state_r <= S_FETCH;
              end
              `CPUAM_OP_CALL: begin
                exc_r <= 1'b0;
                fetch_ind_r <= 1'b1;
                state_r <= S_PUSH_PC;
              end
              `CPUAM_OP_PREDEC: begin
                gpr_r[cmd_reg] <= reg_dec;
                eff_addr_r <= eff_dec;
              end
              `CPUAM_OP_POSTINC: begin
                gpr_r[cmd_reg] <= reg_inc;
                eff_addr_r <= eff_inc;
              end
              default: begin
                state_r <= S_IDLE;
              end
            endcase
          end
        end
        S_PUSH_PC, S_PUSH_COND, S_PUSH_XCTL: begin
          if (!mem_req) begin
            gpr_r[7] <= sp_dec;
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_long <= push_long;
            mem_addr <= push_addr;
            mem_wdata <= push_data_nxt;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state_r <= push_state_nxt;
          end
        end
        S_FETCH: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_long <= adv_r;
            mem_addr <= fetch_addr;
            mem_wdata <= 32'h00000000;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            state_r <= S_IDLE;
            pc_r <= pc_fetched;
            if (exc_r) begin
              cond_r[`CPUAM_COND_I_BIT] <= 1'b1;
              exc_r <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // cpuam_core

// ### verif/cpuam_mem.sv
`timescale 1ns/1ns
module cpuam_mem (
  // clock
  input wire aclk,
  // request
  input wire mem_req,
  input wire mem_we,
  input wire mem_long,
  input wire [23:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [3:0] lat,
  // answer
  output reg [31:0] mem_rdata = 32'h0,
  output reg mem_ack = 1'b0
);
  reg [7:0] m [0:1023];
  reg [3:0] cnt = 4'h0;
  wire [9:0] a = mem_addr[9:0];
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    cnt <= 4'h0;
    if (mem_req && !mem_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_long ? {m[a], m[a+1], m[a+2], m[a+3]} : {16'hc35a, m[a], m[a+1]};
        if (mem_we && mem_long) {m[a], m[a+1], m[a+2], m[a+3]} <= mem_wdata;
        if (mem_we && !mem_long) {m[a], m[a+1]} <= mem_wdata[15:0];
      end
    end
  end
endmodule // cpuam_mem

// ### verif/cpuam_assertions.sv
`timescale 1ns/1ns
module cpuam_assertions (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  input wire mode_pin,
  // register bus
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_arready,
  // memory port
  input wire mem_req,
  input wire mem_long,
  input wire [23:0] mem_addr,
  input wire mem_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wait_s;
    mem_req && !mem_ack;
  endsequence
  sequence hold_s;
    mem_req && $stable(mem_addr) && $stable(mem_long);
  endsequence
  mem_hold_a: assert property (wait_s |=> hold_s) else $error("request moved");
  req_drop_a: assert property (mem_req && mem_ack |=> !mem_req) else $error("req held");
  norm_addr_a: assert property (mem_req && !mode_pin |-> mem_addr[23:16] == 8'h00)
    else $error("addr above 64k");
  norm_word_a: assert property (mem_req && !mode_pin |-> !mem_long) else $error("long");
  even_addr_a: assert property (mem_req |-> !mem_addr[0]) else $error("odd addr");
  boot_quiet_a: assert property ($rose(aresetn) |-> !mem_req [*4]) else $error("early");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  ar_block_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
endmodule // cpuam_assertions

// ### verif/test_cpuam_core.sv
`timescale 1ns/1ns
module test_cpuam_core;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg mode_pin = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf, lat = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire mem_req, mem_we, mem_long, mem_ack;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, mem_wdata, mem_rdata;
  wire [23:0] mem_addr;
  integer n_fail = 0, checks = 0, cyc = 0;
  reg slow = 1'b0;
  reg [31:0] got;
  reg [1:0] resp;
  cpuam_core i_cpuam_core (.*);
  cpuam_mem i_cpuam_mem (.*);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    reg pa, pw, busy;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w && !slow;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w && !slow;
      busy = 1'b1;
      while (busy) begin
        @(negedge aclk);
        pa = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
        pw = s_axi_wvalid && s_axi_wready;
        busy = w ? !s_axi_bvalid : !s_axi_rvalid;
        got = s_axi_rdata;
        resp = w ? s_axi_bresp : s_axi_rresp;
        @(posedge aclk);
        if (pa) s_axi_awvalid <= 1'b0;
        if (pa) s_axi_arvalid <= 1'b0;
        if (pw) s_axi_wvalid <= 1'b0;
      end
      if (slow) begin
        s_axi_bready <= w;
        s_axi_rready <= !w;
        @(posedge aclk);
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      bus(1'b1, a, d);
      chk({30'h0, resp}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      bus(1'b0, a, 32'h0);
      chk(got, e);
      chk({30'h0, resp}, {30'h0, er});
    end
  endtask
  task idle;
    begin
      got = 32'h2;
      while (got[1] !== 1'b0) bus(1'b0, 8'h2c, 32'h0);
    end
  endtask
  task rst(input md);
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      mode_pin <= md;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      idle;
    end
  endtask
  task put(input [9:0] a, input [31:0] d);
    begin
      {i_cpuam_mem.m[a], i_cpuam_mem.m[a+1], i_cpuam_mem.m[a+2], i_cpuam_mem.m[a+3]} = d;
    end
  endtask
  function [31:0] pk(input [9:0] a);
    pk = {i_cpuam_mem.m[a], i_cpuam_mem.m[a+1], i_cpuam_mem.m[a+2], i_cpuam_mem.m[a+3]};
  endfunction
  initial begin
    put(10'h000, 32'h12350000);
    put(10'h004, 32'h00000246);
    put(10'h040, 32'h56789abc);
    rst(1'b0);
    rd(8'h20, 32'h1234, 2'h0);
    rd(8'h24, 32'h7f, 2'h0);
    rd(8'h28, 32'h80, 2'h0);
    rd(8'h2c, 32'h0, 2'h0);
    wr(8'h20, 32'h0, 2'h2);
    rd(8'h3c, 32'h0, 2'h2);
    wr(8'h00, 32'hdeadbeef, 2'h0);
    rd(8'h00, 32'hdeadbeef, 2'h0);
    wr(8'h24, 32'h0, 2'h0);
    rd(8'h24, 32'h78, 2'h0);
    wr(8'h04, 32'habcd0000, 2'h0);
    wr(8'h30, 32'h0105, 2'h0);
    rd(8'h04, 32'habccfffe, 2'h0);
    rd(8'h34, 32'h00fffe, 2'h0);
    wr(8'h08, 32'h5a5a0010, 2'h0);
    wr(8'h30, 32'h0206, 2'h0);
    rd(8'h08, 32'h5a5a0012, 2'h0);
    lat <= 4'h3;
    wr(8'h30, 32'h410003, 2'h0);
    idle;
    rd(8'h20, 32'h5678, 2'h0);
    wr(8'h1c, 32'h200, 2'h0);
    wr(8'h30, 32'h420004, 2'h0);
    idle;
    rd(8'h20, 32'h9abc, 2'h0);
    rd(8'h1c, 32'h1fe, 2'h0);
    chk(pk(10'h1fe) >> 16, 32'h5678);
    wr(8'h28, 32'h05, 2'h0);
    wr(8'h30, 32'h030002, 2'h0);
    idle;
    rd(8'h20, 32'h0246, 2'h0);
    rd(8'h28, 32'h85, 2'h0);
    rd(8'h1c, 32'h1f8, 2'h0);
    chk(pk(10'h1fa) >> 24, 32'h05);
    wr(8'h38, 32'h0, 2'h0);
    wr(8'h30, 32'h030002, 2'h0);
    idle;
    rd(8'h1c, 32'h1f4, 2'h0);
    put(10'h000, 32'hff123457);
    put(10'h044, 32'heeabcdee);
    put(10'h048, 32'h00010204);
    rst(1'b1);
    rd(8'h20, 32'h123456, 2'h0);
    rd(8'h2c, 32'h1, 2'h0);
    wr(8'h30, 32'h450003, 2'h0);
    idle;
    rd(8'h20, 32'habcdee, 2'h0);
    wr(8'h1c, 32'h300, 2'h0);
    wr(8'h30, 32'h480004, 2'h0);
    idle;
    rd(8'h20, 32'h010204, 2'h0);
    rd(8'h1c, 32'h2fc, 2'h0);
    chk(pk(10'h2fc), 32'h00abcdee);
    slow = 1'b1;
    wr(8'h10, 32'h01000000, 2'h0);
    wr(8'h30, 32'h1405, 2'h0);
    rd(8'h10, 32'h00fffffc, 2'h0);
    rd(8'h34, 32'hfffffc, 2'h0);
    give_verdict;
  end
endmodule // test_cpuam_core
bind cpuam_core cpuam_assertions i_cpuam_assertions (.*);
